// ===== rtl/boot_serial_inquiry_select_handler.sv
// Functional notes
// - erased-block inquiry answers code, size, count, start/last addresses, checksum
// - programming-unit inquiry answers code, size two, two-byte unit, checksum
// - new-rate frame: code, size, rate, input frequency, count, two ratios, sum
// - rate field holds bits per second divided by one hundred
// - input frequency field holds megahertz times one hundred
// - ratio byte: positive multiplier or negative two's complement divider
// - settable rate gets acknowledge, otherwise rate error code and one code byte
// - rate error codes include checksum failure and unavailable rate
// - rate error codes include input frequency, ratio and operating frequency
// - input frequency must lie inside the clock mode's range
// - each ratio must match the supported one for the clock mode
// - operating frequency is input times multiplier or over divider, range checked
// - prescale and divisor derived from peripheral clock; rate error below four percent
// - error equals clock over divisor, rate, 64 and prescale, minus one
// - new rate applied after acknowledge leaves; confirmation answered at new rate
// - transition erases user areas, then acknowledges and enters programming state
// - failed erase answers transition error code and erase error code
// - bad, misordered or unacceptable command answers error code and command byte
// - clock mode before device, or inquiry after transition, is a command error
// - the new-rate frame sums to zero modulo 256, checked by the device; single-byte commands carry no sum
`timescale 1ns/1ps
`include "boot_inquiry_regs.svh"

module boot_serial_inquiry_select_handler
    import boot_inquiry_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        tx_ready,
    input  wire logic        tx_idle,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        device_selected,
    input  wire logic        clock_mode_selected,
    input  wire logic [15:0] in_freq_min,
    input  wire logic [15:0] in_freq_max,
    input  wire logic [15:0] op_freq_min,
    input  wire logic [15:0] op_freq_max,
    input  wire logic [7:0]  main_ratio_allowed,
    input  wire logic [7:0]  periph_ratio_allowed,
    input  wire logic [7:0]  erased_count,
    input  wire logic [31:0] erased_start,
    input  wire logic [31:0] erased_last,
    output logic      [7:0]  erased_index,
    output logic             erase_start,
    input  wire logic        erase_done,
    input  wire logic        erase_ok,
    output logic             baud_apply,
    output logic      [1:0]  prescale_select_field,
    output logic      [7:0]  baud_divisor_register,
    output logic             prog_mode
);

    typedef struct packed {
        state_e          st;
        resp_e           rsp;
        logic [7:0]      size;
        logic [3:0]      cnt;
        logic [7:0][7:0] body;
        logic [7:0]      sum;
        logic [7:0]      code;
        logic [7:0]      arg;
        logic [9:0]      pos;
        logic [7:0]      blk;
        logic [2:0]      k;
        logic [7:0]      tsum;
        logic            tx_valid;
        logic [7:0]      tx_data;
        logic            rate_pend;
        logic            rate_done;
        logic [1:0]      pend_sel;
        logic [7:0]      pend_div;
        logic [1:0]      sel;
        logic [7:0]      div;
        logic            baud_apply;
        logic            erase_start;
        logic            prog_mode;
    } state_s;

    state_s s;
    state_s next_s;

    // multiplier or two's complement divider applied to a frequency
    function automatic logic [23:0] scale(input logic [15:0] f, input logic [7:0] r);
        logic [7:0] mag;
        mag = 8'(~r + 8'h01);
        if (!r[7])
            return 24'(f) * 24'(r);
        else
            return 24'(f) / 24'(mag);
    endfunction

    // returns {ok, divisor} for prescale n; base = rate*64*2^(2n-1) in rate units
    function automatic logic [8:0] baud_try(input logic [23:0] pf, input logic [15:0] br,
                                            input logic [1:0] n);
        logic [35:0] base;
        logic [35:0] num;
        logic [35:0] q;
        logic [35:0] d;
        logic [35:0] diff;
        logic        ok;
        base = 36'(br) << (`BAUD_BASE_SHIFT + 6'({n, 1'b0}));
        num  = 36'(pf) * `FREQ_TO_RATE;
        q    = (br == 16'h0000) ? 36'h0 : (num + (base >> 1)) / base;
        d    = base * q;
        diff = (num > d) ? num - d : d - num;
        ok   = (q != 36'h0) && (q <= `DIV_MAX) && (diff * `RATE_ERR_INV < d);
        return {ok, 8'(q - 36'h1)};
    endfunction

    function automatic state_s start_tx(input state_s c, input resp_e r,
                                        input logic [7:0] code, input logic [7:0] arg);
        state_s t;
        t      = c;
        t.st   = S_TX;
        t.rsp  = r;
        t.code = code;
        t.arg  = arg;
        t.pos  = 10'h000;
        t.blk  = 8'h00;
        t.k    = 3'h0;
        t.tsum = 8'h00;
        return t;
    endfunction

    // new-rate frame fields
    logic [15:0] br;
    logic [15:0] in_freq;
    logic [23:0] pf_main;
    logic [23:0] pf_periph;
    logic        rate_ok;
    logic [1:0]  rate_sel;
    logic [7:0]  rate_div;
    logic [8:0]  try_res;
    logic [7:0]  check_code;

    assign br        = {s.body[0], s.body[1]};
    assign in_freq   = {s.body[2], s.body[3]};
    assign pf_main   = scale(in_freq, s.body[5]);
    assign pf_periph = scale(in_freq, s.body[6]);

    // smallest prescale that fits wins
    always_comb
    begin
        rate_ok  = 1'b0;
        rate_sel = 2'h0;
        rate_div = 8'h00;
        try_res  = 9'h000;
        for (int i = 3; i >= 0; i--)
        begin
            try_res = baud_try(pf_periph, br, 2'(i));
            if (try_res[8])
            begin
                rate_ok  = 1'b1;
                rate_sel = 2'(i);
                rate_div = try_res[7:0];
            end
        end
    end

    always_comb
    begin
        if (in_freq < in_freq_min || in_freq > in_freq_max)
            check_code = `ERR_IN_FREQ;
        else if (s.body[4] != `RATIO_COUNT || s.body[5] != main_ratio_allowed
                 || s.body[6] != periph_ratio_allowed || s.body[5] == 8'h00)
            check_code = `ERR_RATIO;
        else if (pf_main < 24'(op_freq_min) || pf_main > 24'(op_freq_max)
                 || pf_periph < 24'(op_freq_min) || pf_periph > 24'(op_freq_max))
            check_code = `ERR_OP_FREQ;
        else if (!rate_ok)
            check_code = `ERR_RATE;
        else
            check_code = 8'h00;
    end

    // response byte generator
    logic [9:0] tx_len;
    logic [7:0] tx_byte;
    logic [31:0] addr_word;
    logic [1:0]  addr_lane;

    assign addr_word = s.k[2] ? erased_last : erased_start;
    assign addr_lane = 2'(2'h3 - s.k[1:0]);

    always_comb
    begin
        tx_len  = 10'h001;
        tx_byte = `RSP_ACK;
        unique case (s.rsp)
            RESP_ACK:
            begin
                tx_len  = 10'h001;
                tx_byte = `RSP_ACK;
            end
            RESP_ERR2:
            begin
                tx_len  = 10'h002;
                tx_byte = (s.pos == 10'h000) ? s.code : s.arg;
            end
            RESP_UNIT:
            begin
                tx_len = 10'h005;
                unique case (s.pos[2:0])
                    3'h0:    tx_byte = `RSP_UNIT;
                    3'h1:    tx_byte = `UNIT_SIZE;
                    3'h2:    tx_byte = 8'(`PROG_UNIT >> 8);
                    3'h3:    tx_byte = 8'(`PROG_UNIT & 16'h00FF);
                    default: tx_byte = 8'(8'h00 - s.tsum);
                endcase
            end
            RESP_ERASED:
            begin
                tx_len = 10'(10'h004 + {erased_count, 3'h0});
                if (s.pos == 10'h000)
                    tx_byte = `RSP_ERASED;
                else if (s.pos == 10'h001)
                    tx_byte = 8'(8'h01 + {erased_count[4:0], 3'h0});
                else if (s.pos == 10'h002)
                    tx_byte = erased_count;
                else if (s.pos == tx_len - 10'h001)
                    tx_byte = 8'(8'h00 - s.tsum);
                else
                    tx_byte = addr_word[{addr_lane, 3'h0} +: 8];
            end
        endcase
    end

    logic inq_legal;
    assign inq_legal = device_selected && clock_mode_selected && !s.prog_mode;

    always_comb
    begin
        next_s             = s;
        next_s.baud_apply  = 1'b0;
        next_s.erase_start = 1'b0;
        if (s.tx_valid && tx_ready)
            next_s.tx_valid = 1'b0;
        unique case (s.st)
            S_CMD:
            begin
                if (rx_valid)
                begin
                    next_s.sum = rx_data;
                    next_s.cnt = 4'h0;
                    if (rx_data == `CMD_ERASED_INQ && inq_legal)
                        next_s = start_tx(next_s, RESP_ERASED, 8'h00, 8'h00);
                    else if (rx_data == `CMD_UNIT_INQ && inq_legal)
                        next_s = start_tx(next_s, RESP_UNIT, 8'h00, 8'h00);
                    else if (rx_data == `CMD_NEW_RATE && inq_legal)
                        next_s.st = S_SIZE;
                    else if (rx_data == `CMD_TRANSITION && inq_legal && s.rate_done)
                    begin
                        next_s.st          = S_ERASE;
                        next_s.erase_start = 1'b1;
                    end
                    else
                        next_s = start_tx(next_s, RESP_ERR2, `RSP_CMD_ERR, rx_data);
                end
            end
            S_SIZE:
            begin
                if (rx_valid)
                begin
                    next_s.size = rx_data;
                    next_s.sum  = 8'(s.sum + rx_data);
                    next_s.st   = (rx_data == 8'h00) ? S_SUM : S_BODY;
                end
            end
            S_BODY:
            begin
                if (rx_valid)
                begin
                    if (s.cnt < `BODY_MAX)
                        next_s.body[3'(s.cnt)] = rx_data;
                    next_s.sum = 8'(s.sum + rx_data);
                    if (s.cnt != 4'hF)
                        next_s.cnt = 4'(s.cnt + 4'h1);
                    if (8'(s.cnt) + 8'h01 >= s.size)
                        next_s.st = S_SUM;
                end
            end
            S_SUM:
            begin
                if (rx_valid)
                begin
                    if (8'(s.sum + rx_data) == 8'h00)
                        next_s.st = S_CHECK;
                    else
                        next_s = start_tx(next_s, RESP_ERR2, `RSP_RATE_ERR, `ERR_SUM);
                end
            end
            S_CHECK:
            begin
                if (check_code == 8'h00)
                begin
                    next_s           = start_tx(next_s, RESP_ACK, 8'h00, 8'h00);
                    next_s.rate_pend = 1'b1;
                    next_s.pend_sel  = rate_sel;
                    next_s.pend_div  = rate_div;
                end
                else
                    next_s = start_tx(next_s, RESP_ERR2, `RSP_RATE_ERR, check_code);
            end
            S_TX:
            begin
                if (!next_s.tx_valid)
                begin
                    if (s.pos == tx_len)
                        next_s.st = s.rate_pend ? S_APPLY : S_CMD;
                    else
                    begin
                        next_s.tx_valid = 1'b1;
                        next_s.tx_data  = tx_byte;
                        next_s.tsum     = 8'(s.tsum + tx_byte);
                        next_s.pos      = 10'(s.pos + 10'h001);
                        if (s.rsp == RESP_ERASED && s.pos >= 10'h003)
                        begin
                            next_s.k = 3'(s.k + 3'h1);
                            if (s.k == 3'h7)
                                next_s.blk = 8'(s.blk + 8'h01);
                        end
                    end
                end
            end
            S_APPLY:
            begin
                if (tx_idle)
                begin
                    next_s.baud_apply = 1'b1;
                    next_s.sel        = s.pend_sel;
                    next_s.div        = s.pend_div;
                    next_s.rate_pend  = 1'b0;
                    next_s.st         = S_CONFIRM;
                end
            end
            S_CONFIRM:
            begin
                if (rx_valid)
                begin
                    if (rx_data == `RSP_ACK)
                    begin
                        next_s           = start_tx(next_s, RESP_ACK, 8'h00, 8'h00);
                        next_s.rate_done = 1'b1;
                    end
                    else
                        next_s = start_tx(next_s, RESP_ERR2, `RSP_CMD_ERR, rx_data);
                end
            end
            S_ERASE:
            begin
                if (erase_done)
                begin
                    if (erase_ok)
                    begin
                        next_s           = start_tx(next_s, RESP_ACK, 8'h00, 8'h00);
                        next_s.prog_mode = 1'b1;
                    end
                    else
                        next_s = start_tx(next_s, RESP_ERR2, `RSP_TRANS_ERR, `ERR_ERASE);
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s      <= '0;
            s.st   <= S_CMD;
            s.rsp  <= RESP_ACK;
        end
        else
            s <= next_s;
    end

    assign tx_data               = s.tx_data;
    assign tx_valid              = s.tx_valid;
    assign erased_index          = s.blk;
    assign erase_start           = s.erase_start;
    assign baud_apply            = s.baud_apply;
    assign prescale_select_field = s.sel;
    assign baud_divisor_register = s.div;
    assign prog_mode             = s.prog_mode;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_tx_hold_data: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte dropped or changed before acceptance");
    a_apply_line_idle: assert property (baud_apply |-> !tx_valid && $past(tx_idle))
        else $error("new rate applied while a byte is pending");
    a_divisor_only_apply: assert property (!baud_apply |-> $stable(baud_divisor_register))
        else $error("divisor changed without apply");
    a_confirm_ack: assert property (s.st == S_CONFIRM && rx_valid && rx_data == `RSP_ACK
        |-> ##2 tx_valid && tx_data == `RSP_ACK)
        else $error("confirmation not acknowledged");
    a_prog_after_erase: assert property ($rose(prog_mode) |-> $past(erase_done && erase_ok))
        else $error("programming state entered without erase");
    a_erase_fail_code: assert property (s.st == S_ERASE && erase_done && !erase_ok
        |-> ##2 tx_valid && tx_data == `RSP_TRANS_ERR)
        else $error("erase failure not reported");
    a_inquiry_after_prog: assert property (s.st == S_CMD && rx_valid && prog_mode
        |-> ##2 tx_valid && tx_data == `RSP_CMD_ERR)
        else $error("command accepted after transition");
    a_unit_first_byte: assert property (s.st == S_CMD && rx_valid && inq_legal
        && rx_data == `CMD_UNIT_INQ |-> ##2 tx_valid && tx_data == `RSP_UNIT)
        else $error("unit inquiry answered wrongly");
    a_erased_first_byte: assert property (s.st == S_CMD && rx_valid && inq_legal
        && rx_data == `CMD_ERASED_INQ |-> ##2 tx_valid && tx_data == `RSP_ERASED)
        else $error("erased block inquiry answered wrongly");
    a_sum_fail_code: assert property (s.st == S_SUM && rx_valid
        && 8'(s.sum + rx_data) != 8'h00 |-> ##2 tx_valid && tx_data == `RSP_RATE_ERR
        ##[1:1000] tx_valid && tx_data == `ERR_SUM)
        else $error("checksum failure not reported");

    c_rate_applied: cover property (baud_apply);
    c_confirm_done: cover property (s.st == S_CONFIRM && rx_valid && rx_data == `RSP_ACK);
    c_prog_entered: cover property ($rose(prog_mode));
    c_rate_error: cover property (s.st == S_CHECK && check_code != 8'h00);

endmodule

// ===== rtl/boot_inquiry_regs.svh
`ifndef BOOT_INQUIRY_REGS_SVH
`define BOOT_INQUIRY_REGS_SVH

`define CMD_ERASED_INQ   8'h26
`define CMD_UNIT_INQ     8'h27
`define CMD_NEW_RATE     8'h3F
`define CMD_TRANSITION   8'h40
`define RSP_ERASED       8'h36
`define RSP_UNIT         8'h37
`define RSP_ACK          8'h06
`define RSP_RATE_ERR     8'hBF
`define RSP_TRANS_ERR    8'hC0
`define RSP_CMD_ERR      8'h80
`define ERR_SUM          8'h11
`define ERR_RATE         8'h24
`define ERR_IN_FREQ      8'h25
`define ERR_RATIO        8'h26
`define ERR_OP_FREQ      8'h27
`define ERR_ERASE        8'h51
`define UNIT_SIZE        8'h02
`define PROG_UNIT        16'h0080
`define RATIO_COUNT      8'h02
`define BODY_MAX         4'h8
`define BLOCK_BYTES      8'h08
`define FREQ_TO_RATE     36'h0_0000_0064
`define BAUD_BASE_SHIFT  6'h05
`define RATE_ERR_INV     36'h0_0000_0019
`define DIV_MAX          36'h0_0000_0100

`endif

// ===== rtl/boot_inquiry_pkg.sv
package boot_inquiry_pkg;

    typedef enum logic [3:0] {
        S_CMD,
        S_SIZE,
        S_BODY,
        S_SUM,
        S_CHECK,
        S_TX,
        S_APPLY,
        S_CONFIRM,
        S_ERASE
    } state_e;

    typedef enum logic [1:0] {
        RESP_ACK,
        RESP_ERR2,
        RESP_ERASED,
        RESP_UNIT
    } resp_e;

endpackage

// ===== testbench/host_link_model.sv
`timescale 1ns/1ps
module host_link_model
(
    input  wire logic       core_clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            tx_idle,
    output logic      [7:0] rx_data,
    output logic            rx_valid
);
    logic [7:0] got[$];
    int         byte_time = 3;
    int         busy      = 0;

    initial
    begin
        tx_ready = 1'b1;
        tx_idle  = 1'b1;
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end

    // the line carries one byte for byte_time cycles after each accept
    always @(posedge core_clk)
    begin
        if (tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
            busy = byte_time;
        end
        else if (busy != 0)
            busy = busy - 1;
    end

    always @(negedge core_clk)
    begin
        tx_ready <= (busy == 0);
        tx_idle  <= (busy == 0);
    end

    task automatic send_byte(input logic [7:0] b);
        @(negedge core_clk);
        rx_data  = b;
        rx_valid = 1'b1;
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data  = ~b; // no stale byte left on the bus
        repeat (2) @(negedge core_clk);
    endtask

    task automatic send_frame(input logic [7:0] f[$], input logic add_sum);
        logic [7:0] s;
        s = 8'h00;
        foreach (f[i])
        begin
            s = s - f[i];
            send_byte(f[i]);
        end
        if (add_sum)
            send_byte(s);
    endtask

    // sent only once the acknowledge has arrived and the line has switched
    task automatic confirm_rate();
        send_byte(8'h06);
    endtask
endmodule

// ===== testbench/boot_serial_inquiry_select_handler_test.sv
`timescale 1ns/1ps
module boot_serial_inquiry_select_handler_test;
    typedef logic [7:0] bq_t[$];
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  rx_data, tx_data, erased_index, baud_divisor_register, apply_acked;
    logic        rx_valid, tx_ready, tx_idle, tx_valid, erase_start, baud_apply;
    logic        prog_mode, apply_idle, erase_done = 1'b0, erase_ok = 1'b0;
    logic        device_selected = 1'b0, clock_mode_selected = 1'b0;
    logic [15:0] in_min = 16'h0000, in_max = 16'h0000, op_min = 16'h0000;
    logic [15:0] op_freq_max = 16'h0000;
    logic [7:0]  erased_count = 8'h00, main_allowed = 8'h00, periph_allowed = 8'h00;
    logic [31:0] blk_start, blk_last;
    logic [1:0]  prescale_select_field;
    int          erase_t = 0, n_erase = 0, n_apply = 0, n_errors = 0, n_compared = 0;

    always #12.5 core_clk = ~core_clk;
    assign blk_start = {16'h0000, erased_index, 8'h00};
    assign blk_last  = {16'h0000, erased_index, 8'hFF};

    boot_serial_inquiry_select_handler u_dut (
        .core_clk(core_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .tx_idle(tx_idle), .tx_data(tx_data), .tx_valid(tx_valid),
        .device_selected(device_selected), .clock_mode_selected(clock_mode_selected),
        .in_freq_min(in_min), .in_freq_max(in_max), .op_freq_min(op_min),
        .op_freq_max(op_freq_max), .main_ratio_allowed(main_allowed),
        .periph_ratio_allowed(periph_allowed), .erased_count(erased_count),
        .erased_start(blk_start), .erased_last(blk_last), .erased_index(erased_index),
        .erase_start(erase_start), .erase_done(erase_done), .erase_ok(erase_ok),
        .baud_apply(baud_apply), .prescale_select_field(prescale_select_field),
        .baud_divisor_register(baud_divisor_register), .prog_mode(prog_mode));

    host_link_model u_host (
        .core_clk(core_clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_idle(tx_idle), .rx_data(rx_data), .rx_valid(rx_valid));

    // erase engine stand-in: done pulse a few cycles after each start
    always @(negedge core_clk)
    begin
        erase_done <= 1'b0;
        if (erase_start)
        begin
            erase_t <= 6;
            n_erase <= n_erase + 1;
        end
        else if (erase_t != 0)
        begin
            erase_t    <= erase_t - 1;
            erase_done <= (erase_t == 1);
        end
    end

    always @(posedge core_clk)
    begin
        if (baud_apply)
        begin
            n_apply++;
            apply_acked = 8'(u_host.got.size());
            apply_idle  = tx_idle;
        end
    end

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic bq_t with_sum(input bq_t q);
        logic [7:0] s;
        s = 8'h00;
        foreach (q[i])
            s = s - q[i];
        return {q, s};
    endfunction

    task automatic expect_resp(input string what, input bq_t exp);
        int n;
        n = 0;
        while (u_host.got.size() < exp.size() && n < 2000)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (20) @(negedge core_clk);
        check_byte({what, " count"}, 8'(exp.size()), 8'(u_host.got.size()));
        if (u_host.got.size() == exp.size())
            foreach (exp[i])
                check_byte(what, exp[i], u_host.got[i]);
        u_host.got.delete();
    endtask

    function automatic bq_t rate_frame(input logic [15:0] r, input logic [15:0] f,
                                       input logic [7:0] c, input logic [7:0] m);
        return '{8'h3F, 8'h07, r[15:8], r[7:0], f[15:8], f[7:0], c, m, 8'h02};
    endfunction

    task automatic t_order();
        u_host.send_byte(8'h27);
        expect_resp("early inquiry", '{8'h80, 8'h27});
        device_selected = 1'b1;
        u_host.send_byte(8'h26);
        expect_resp("no clock mode", '{8'h80, 8'h26});
        u_host.send_byte(8'h55);
        expect_resp("undefined", '{8'h80, 8'h55});
        clock_mode_selected = 1'b1;
        // limits and ratios of the selected clock mode
        in_min         = 16'h03E8;
        in_max         = 16'h09C4;
        op_min         = 16'h0320;
        op_freq_max    = 16'h2710;
        main_allowed   = 8'h04;
        periph_allowed = 8'h02;
        u_host.send_byte(8'h40);
        expect_resp("early transition", '{8'h80, 8'h40});
        $display("test order done");
    endtask

    task automatic t_inquiries();
        bq_t q;
        q = '{8'h36, 8'h11, 8'h02};
        for (int i = 0; i < 2; i++)
            q = {q, 8'h00, 8'h00, i[7:0], 8'h00, 8'h00, 8'h00, i[7:0], 8'hFF};
        u_host.send_byte(8'h27);
        expect_resp("unit", with_sum('{8'h37, 8'h02, 8'h00, 8'h80}));
        u_host.send_byte(8'h26);
        expect_resp("erased none", with_sum('{8'h36, 8'h01, 8'h00}));
        erased_count = 8'h02;
        u_host.send_byte(8'h26);
        expect_resp("erased", with_sum(q));
        $display("test inquiries done");
    endtask

    task automatic t_rate_errors();
        logic [15:0] rv[7] = '{16'h00C0, 16'h00C0, 16'h00C0, 16'h00C0, 16'h00C0, 16'hFFFF,
                               16'h00C0};
        logic [15:0] fv[7] = '{16'h07D0, 16'h0BB8, 16'h07D0, 16'h07D0, 16'h07D0, 16'h07D0,
                               16'h0320};
        logic [7:0]  cv[7] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h02, 8'h02, 8'h02};
        logic [7:0]  mv[7] = '{8'h04, 8'h04, 8'h08, 8'h04, 8'h04, 8'hFE, 8'h04};
        logic [7:0]  ev[7] = '{8'h11, 8'h25, 8'h26, 8'h26, 8'h27, 8'h24, 8'h25};
        for (int i = 0; i < 7; i++)
        begin
            op_freq_max  = (i == 4) ? 16'h1770 : 16'h2710;
            main_allowed = (i == 5) ? 8'hFE : 8'h04;
            u_host.send_frame(rate_frame(rv[i], fv[i], cv[i], mv[i]), i != 0);
            if (i == 0)
                u_host.send_byte(8'h00);
            expect_resp("rate error", '{8'hBF, ev[i]});
        end
        check_byte("apply count", 8'h00, 8'(n_apply));
        $display("test rate errors done");
    endtask

    task automatic t_rate();
        logic [15:0] rv[2] = '{16'h00C0, 16'h0018};
        logic [7:0]  nv[2] = '{8'h00, 8'h01};
        logic [7:0]  dv[2] = '{8'h40, 8'h81};
        for (int i = 0; i < 2; i++)
        begin
            u_host.byte_time = 12;
            // 19200 then 2400 bps from 20.00 MHz, main x4, peripheral x2
            u_host.send_frame(rate_frame(rv[i], 16'h07D0, 8'h02, 8'h04), 1'b1);
            expect_resp("rate ack", '{8'h06});
            check_byte("apply count", 8'(i + 1), 8'(n_apply));
            check_byte("ack before apply", 8'h01, apply_acked);
            check_byte("idle at apply", 8'h01, 8'(apply_idle));
            check_byte("prescale", nv[i], 8'(prescale_select_field));
            check_byte("divisor", dv[i], baud_divisor_register);
            u_host.byte_time = 0;
            u_host.confirm_rate();
            expect_resp("confirm ack", '{8'h06});
        end
        $display("test rate done");
    endtask

    task automatic t_transition();
        u_host.send_byte(8'h40);
        expect_resp("erase fail", '{8'hC0, 8'h51});
        check_byte("mode after fail", 8'h00, 8'(prog_mode));
        erase_ok = 1'b1;
        u_host.send_byte(8'h40);
        expect_resp("transition", '{8'h06});
        check_byte("erase count", 8'h02, 8'(n_erase));
        check_byte("mode", 8'h01, 8'(prog_mode));
        u_host.send_byte(8'h27);
        expect_resp("late inquiry", '{8'h80, 8'h27});
        $display("test transition done");
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        check_byte("idle tx", 8'h00, 8'(tx_valid));
        t_order();
        t_inquiries();
        t_rate_errors();
        t_rate();
        t_transition();
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check_byte("mode after reset", 8'h00, 8'(prog_mode));
        check_byte("divisor after reset", 8'h00, baud_divisor_register);
        tally_and_finish();
    end
endmodule
